// [src/ctzp_consts.svh]
// constants, reset values and timing counts of the charge temperature zone protect block
`ifndef CTZP_CONSTS_SVH
`define CTZP_CONSTS_SVH

// current thresholds in mA
`define CTZP_QUIT_MA 16'h0028
`define CTZP_SLEEP_MA 16'h000F
// load profile defaults: -299 mA and -1131 mW
`define CTZP_AVG_I_MA 16'hFED5
`define CTZP_AVG_P_MW 16'hFB95
`define CTZP_LOAD_SEL 3'h1
// temperatures in 0.1 degC steps
`define CTZP_BND1 16'h0000
`define CTZP_BND2 16'h0064
`define CTZP_BND3 16'h01C2
`define CTZP_BND4 16'h01F4
`define CTZP_BND5 16'h0258
`define CTZP_HYS 16'h000A
`define CTZP_OTC_THR 16'h0226
`define CTZP_OTC_REC 16'h01F4
`define CTZP_OTD_THR 16'h0258
`define CTZP_OTD_REC 16'h0226
// zone charge voltage in mV, current in percent
`define CTZP_V_LOW 16'h10FE
`define CTZP_V_MID 16'h10CC
`define CTZP_V_HIGH 16'h109A
`define CTZP_PCT_COLD 8'h32
`define CTZP_PCT_WARM 8'h50
// overheat delay in seconds and coulomb gain in micro-ohm (5 mOhm)
`define CTZP_OT_DELAY_S 8'h05
`define CTZP_GAIN_UOHM 16'h1388
// timing: one second expressed in clock cycles
`define CTZP_CLK_NS 10
`define CTZP_SEC_NS 1000000000
`define CTZP_SEC_CYC (`CTZP_SEC_NS / `CTZP_CLK_NS)
// conversion scale uV*1000/uOhm gives mA, divider steps, saturation
`define CTZP_UV_SCALE 32'h000003E8
`define CTZP_DIV_STEPS 6'h20
`define CTZP_SAT_MAX 32'h00007FFF
`endif

// [src/ctzp_pkg.sv]
// types shared by the charge temperature zone protect block
package ctzp_pkg;
  // temperature zone, one-hot
  typedef enum logic [5:0] {
    Z_COLD = 6'b000001, Z_12 = 6'b000010, Z_23 = 6'b000100,
    Z_34 = 6'b001000, Z_45 = 6'b010000, Z_HOT = 6'b100000
  } ctzp_zone_t;
  // overheat qualifier state, one-hot
  typedef enum logic [2:0] {
    OT_IDLE = 3'b001, OT_QUAL = 3'b010, OT_TRIP = 3'b100
  } ctzp_ot_t;
  // average current and power of a discharge run
  typedef struct packed {
    logic signed [15:0] avgMa;
    logic signed [15:0] avgMw;
  } ctzp_prof_t;
  // configuration set loaded by the host
  typedef struct packed {
    logic signed [15:0] quitMa, sleepMa;
    logic signed [15:0] zoneBoundaryOne, zoneBoundaryTwo, zoneBoundaryThree;
    logic signed [15:0] zoneBoundaryFour, zoneBoundaryFive, hys;
    logic [15:0] v12, v23, v34, v45;
    logic [7:0] i12, i23, i34, i45;
    logic signed [15:0] chargeOverheatThreshold, chargeOverheatRecover;
    logic signed [15:0] dischargeOverheatThreshold, dischargeOverheatRecover;
    logic [7:0] chargeOverheatDelay, dischargeOverheatDelay;
    logic [15:0] coulombGain;
    logic [2:0] loadSel;
  } ctzp_cfg_t;
endpackage

// [src/ctzp_cc_div.sv]
// restoring divider turning sense voltage into current
`timescale 1ns/1ps
`include "ctzp_consts.svh"
module ctzp_cc_div (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic start, // begin a division
  input wire logic [31:0] dividend, // scaled sense voltage
  input wire logic [15:0] divisor, // coulomb gain
  output logic busy, // division running
  output logic done, // one-cycle result strobe
  output logic [31:0] quotient // magnitude in mA
);
  logic [15:0] rem; // partial remainder
  logic [5:0] steps; // steps left
  logic [17:0] diff; // trial subtraction
  // one quotient bit per cycle
  always_comb begin
    diff = {1'b0, rem, quotient[31]} - {2'b00, divisor};
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rem <= 16'h0000;
      steps <= 6'h00;
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= 32'h00000000;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        quotient <= dividend;
        rem <= 16'h0000;
        steps <= `CTZP_DIV_STEPS;
        busy <= 1'b1;
      end else if (busy) begin
        // zero gain ends with all ones, which saturates upstream
        rem <= diff[17] ? {rem[14:0], quotient[31]} : diff[15:0];
        quotient <= {quotient[30:0], ~diff[17]};
        steps <= steps - 6'h01;
        busy <= (steps != 6'h01);
        done <= (steps == 6'h01);
      end
    end
  end
endmodule // ctzp_cc_div

// [src/ctzp_ot_qual.sv]
// overheat qualifier: prohibit, delayed switch off, recovery
`timescale 1ns/1ps
module ctzp_ot_qual #(
  parameter int unsigned SEC_CYC = 100000000 // cycles per second
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset
  input wire logic ce, // clock enable
  input wire logic signed [15:0] tempDc, // temperature, 0.1 degC
  input wire logic signed [15:0] tripDc, // overheat threshold
  input wire logic signed [15:0] recoverDc, // recovery threshold
  input wire logic [7:0] delaySec, // qualification delay
  output logic prohibit, // overheat seen
  output logic switchOn // power switch enable
);
  import ctzp_pkg::*;
  ctzp_ot_t state; // qualifier state
  logic [31:0] cycCnt; // cycles within the second
  logic [7:0] secCnt; // whole seconds elapsed
  // state machine with timer restarted on each entry
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= OT_IDLE;
      cycCnt <= 32'h00000000;
      secCnt <= 8'h00;
      prohibit <= 1'b0;
      switchOn <= 1'b1;
    end else if (ce) begin
      case (state)
        OT_IDLE: begin
          cycCnt <= 32'h00000000;
          secCnt <= 8'h00;
          if (tempDc >= tripDc) begin
            prohibit <= 1'b1;
            state <= (delaySec == 8'h00) ? OT_TRIP : OT_QUAL;
            switchOn <= (delaySec != 8'h00);
          end
        end
        OT_QUAL: begin
          if (tempDc < tripDc) begin
            state <= OT_IDLE;
            prohibit <= 1'b0;
          end else if (cycCnt == 32'(SEC_CYC - 1)) begin
            cycCnt <= 32'h00000000;
            secCnt <= secCnt + 8'h01;
            if (secCnt + 8'h01 >= delaySec) begin
              state <= OT_TRIP;
              switchOn <= 1'b0;
            end
          end else begin
            cycCnt <= cycCnt + 32'h00000001;
          end
        end
        OT_TRIP: begin
          if (tempDc <= recoverDc) begin
            state <= OT_IDLE;
            prohibit <= 1'b0;
            switchOn <= 1'b1;
          end
        end
        default: begin
          state <= OT_IDLE;
          prohibit <= 1'b0;
          switchOn <= 1'b1;
        end
      endcase
    end
  end
  // cooling below the threshold early keeps the switch on
  early_cool_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && state == OT_QUAL && tempDc < tripDc |=> switchOn && !prohibit)
    else $error("switch dropped on early cool-down");
  // trip releases at recovery temperature
  trip_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && state == OT_TRIP && tempDc <= recoverDc |=> switchOn && !prohibit)
    else $error("overheat did not recover");
endmodule // ctzp_ot_qual

// [src/ctzp_top.sv]
// charge temperature zone protect: current, load profile, zones, overheat
`timescale 1ns/1ps
`include "ctzp_consts.svh"
module ctzp_top #(
  parameter int unsigned SEC_CYC = `CTZP_SEC_CYC // cycles per second
) (
  input wire logic clk_sys, // 100 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic ce, // clock enable, freezes state
  input wire ctzp_pkg::ctzp_cfg_t cfgIn, // new configuration
  input wire logic cfgLoad, // load cfgIn this cycle
  input wire logic signed [19:0] senseUv, // sense resistor voltage, uV
  input wire logic senseValid, // new sense sample
  input wire logic signed [15:0] tempDc, // temperature, 0.1 degC
  input wire logic signed [15:0] livePowerMw, // present power, mW
  input wire logic dsgOnset, // discharge starting
  input wire logic cycleUpdate, // end of discharge run
  input wire ctzp_pkg::ctzp_prof_t runAvg, // run averages
  input wire logic sleepReq, // system asks for sleep
  input wire logic chgStart, // charger begins an event
  input wire logic chgStop, // charger ends the event
  output logic signed [15:0] currentMa, // converted current, mA
  output logic relaxing, // battery relaxing
  output logic sleeping, // sleep state
  output logic signed [15:0] simCurrentMa, // current for simulation
  output logic signed [15:0] simPowerMw, // power for simulation
  output ctzp_pkg::ctzp_zone_t zoneNow, // active zone
  output logic [15:0] chgVoltMv, // reported charge voltage
  output logic [7:0] chgCurPct, // reported charge current
  output logic chargeAllow, // charging may proceed
  output logic chargeProhibit, // charge overheat
  output logic dischargeProhibit, // discharge overheat
  output logic chargeSwitch, // charge switch enable
  output logic dischargeSwitch // discharge switch enable
);
  import ctzp_pkg::*;

  // magnitude of a signed 16-bit value, saturating at the top
  function automatic logic [15:0] abs16(input logic signed [15:0] v);
    if (v == 16'sh8000) begin
      return 16'h7FFF;
    end
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  // true when temperature sits below a boundary less hysteresis
  function automatic logic below(input logic signed [15:0] t,
                                 input logic signed [15:0] b,
                                 input logic signed [15:0] h);
    logic signed [16:0] lim;
    lim = 17'(b) - 17'(h);
    return 17'(t) < lim;
  endfunction

  // true when a zone allows charging at all
  function automatic logic zoneCharges(input ctzp_zone_t z);
    return (z == Z_12) || (z == Z_23) || (z == Z_34) || (z == Z_45);
  endfunction

  ctzp_cfg_t cfg; // active configuration
  ctzp_prof_t stored; // stored load profile
  ctzp_zone_t next_zone; // zone for next cycle
  logic signPend; // sign of sample in flight
  logic [19:0] magUv; // sample magnitude
  logic [31:0] divQuot; // divider result
  logic divBusy; // divider running
  logic divDone; // divider result strobe
  logic chargeRun; // charging event open
  logic otcProhibit; // charge overheat from qualifier
  logic otcSwitch; // charge switch from qualifier
  logic otdProhibit; // discharge overheat from qualifier
  logic otdSwitch; // discharge switch from qualifier
  logic [15:0] absCur; // current magnitude

  // configuration registers, defaults at reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg.quitMa <= `CTZP_QUIT_MA;
      cfg.sleepMa <= `CTZP_SLEEP_MA;
      cfg.zoneBoundaryOne <= `CTZP_BND1;
      cfg.zoneBoundaryTwo <= `CTZP_BND2;
      cfg.zoneBoundaryThree <= `CTZP_BND3;
      cfg.zoneBoundaryFour <= `CTZP_BND4;
      cfg.zoneBoundaryFive <= `CTZP_BND5;
      cfg.hys <= `CTZP_HYS;
      cfg.v12 <= `CTZP_V_LOW;
      cfg.v23 <= `CTZP_V_LOW;
      cfg.v34 <= `CTZP_V_MID;
      cfg.v45 <= `CTZP_V_HIGH;
      cfg.i12 <= `CTZP_PCT_COLD;
      cfg.i23 <= `CTZP_PCT_WARM;
      cfg.i34 <= `CTZP_PCT_WARM;
      cfg.i45 <= `CTZP_PCT_WARM;
      cfg.chargeOverheatThreshold <= `CTZP_OTC_THR;
      cfg.chargeOverheatRecover <= `CTZP_OTC_REC;
      cfg.dischargeOverheatThreshold <= `CTZP_OTD_THR;
      cfg.dischargeOverheatRecover <= `CTZP_OTD_REC;
      cfg.chargeOverheatDelay <= `CTZP_OT_DELAY_S;
      cfg.dischargeOverheatDelay <= `CTZP_OT_DELAY_S;
      cfg.coulombGain <= `CTZP_GAIN_UOHM;
      cfg.loadSel <= `CTZP_LOAD_SEL;
    end else if (ce && cfgLoad) begin
      cfg <= cfgIn; // whole set replaced at once
    end
  end

  // sample magnitude; sign is carried beside the divider
  always_comb begin
    magUv = senseUv[19] ? 20'(-senseUv) : 20'(senseUv);
  end

  // sample capture: samples arriving while busy are dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      signPend <= 1'b0;
    end else if (ce && senseValid && !divBusy) begin
      signPend <= senseUv[19];
    end
  end

  // uV * 1000 / micro-ohm gives mA
  ctzp_cc_div uDiv (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .start(senseValid && !divBusy),
    .dividend(32'(magUv) * `CTZP_UV_SCALE),
    .divisor(cfg.coulombGain),
    .busy(divBusy),
    .done(divDone),
    .quotient(divQuot)
  );

  // converted current, saturated and signed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      currentMa <= 16'sh0000;
    end else if (ce && divDone) begin
      if (divQuot > `CTZP_SAT_MAX) begin
        currentMa <= signPend ? -16'sh7FFF : 16'sh7FFF;
      end else begin
        currentMa <= signPend ? -$signed(divQuot[15:0]) : $signed(divQuot[15:0]);
      end
    end
  end

  always_comb begin
    absCur = abs16(currentMa);
  end

  // relaxation and sleep by current level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      relaxing <= 1'b0;
      sleeping <= 1'b0;
    end else if (ce) begin
      relaxing <= absCur < cfg.quitMa;
      // higher standby current blocks or ends sleep
      sleeping <= sleepReq && (absCur < cfg.sleepMa);
    end
  end

  // stored profile refreshed at end of each discharge run
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stored.avgMa <= `CTZP_AVG_I_MA;
      stored.avgMw <= `CTZP_AVG_P_MW;
    end else if (ce && cycleUpdate) begin
      stored <= runAvg;
    end
  end

  // simulation load: stored profile at onset or when select is zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      simCurrentMa <= `CTZP_AVG_I_MA;
      simPowerMw <= `CTZP_AVG_P_MW;
    end else if (ce) begin
      if (cfg.loadSel == 3'h0 || dsgOnset) begin
        simCurrentMa <= stored.avgMa;
        simPowerMw <= stored.avgMw;
      end else begin
        simCurrentMa <= currentMa;
        simPowerMw <= livePowerMw;
      end
    end
  end

  // zone walk: rise past a boundary, fall only below boundary less hysteresis
  always_comb begin
    next_zone = zoneNow;
    case (zoneNow)
      Z_COLD: begin
        if (tempDc > cfg.zoneBoundaryOne) next_zone = Z_12;
      end
      Z_12: begin
        if (tempDc > cfg.zoneBoundaryTwo) begin
          next_zone = Z_23;
        end else if (below(tempDc, cfg.zoneBoundaryOne, cfg.hys)) begin
          next_zone = Z_COLD;
        end
      end
      Z_23: begin
        if (tempDc > cfg.zoneBoundaryThree) begin
          next_zone = Z_34;
        end else if (below(tempDc, cfg.zoneBoundaryTwo, cfg.hys)) begin
          next_zone = Z_12;
        end
      end
      Z_34: begin
        if (tempDc > cfg.zoneBoundaryFour) begin
          next_zone = Z_45;
        end else if (below(tempDc, cfg.zoneBoundaryThree, cfg.hys)) begin
          next_zone = Z_23;
        end
      end
      Z_45: begin
        if (tempDc > cfg.zoneBoundaryFive) begin
          next_zone = Z_HOT;
        end else if (below(tempDc, cfg.zoneBoundaryFour, cfg.hys)) begin
          next_zone = Z_34;
        end
      end
      Z_HOT: begin
        if (below(tempDc, cfg.zoneBoundaryFive, cfg.hys)) next_zone = Z_45;
      end
      default: next_zone = Z_COLD;
    endcase
  end

  // zone register, one step per cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      zoneNow <= Z_COLD;
    end else if (ce) begin
      zoneNow <= next_zone;
    end
  end

  // reported charge voltage and current of the active zone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chgVoltMv <= 16'h0000;
      chgCurPct <= 8'h00;
    end else if (ce) begin
      case (zoneNow)
        Z_12: begin
          chgVoltMv <= cfg.v12;
          chgCurPct <= cfg.i12;
        end
        Z_23: begin
          chgVoltMv <= cfg.v23;
          chgCurPct <= cfg.i23;
        end
        Z_34: begin
          chgVoltMv <= cfg.v34;
          chgCurPct <= cfg.i34;
        end
        Z_45: begin
          chgVoltMv <= cfg.v45;
          chgCurPct <= cfg.i45;
        end
        default: begin
          // inhibit or suspend zones report nothing
          chgVoltMv <= 16'h0000;
          chgCurPct <= 8'h00;
        end
      endcase
    end
  end

  // charging event: a new start is refused above boundary four
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chargeRun <= 1'b0;
    end else if (ce) begin
      if (chgStop) begin
        chargeRun <= 1'b0;
      end else if (chgStart && !chargeRun) begin
        chargeRun <= (tempDc <= cfg.zoneBoundaryFour) && !otcProhibit;
      end
    end
  end

  // charge permission: event open, zone charges, no overheat
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chargeAllow <= 1'b0;
    end else if (ce) begin
      chargeAllow <= chargeRun && zoneCharges(zoneNow) && !otcProhibit;
    end
  end

  // charge overheat qualifier
  ctzp_ot_qual #(.SEC_CYC(SEC_CYC)) uOtChg (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .tempDc(tempDc),
    .tripDc(cfg.chargeOverheatThreshold),
    .recoverDc(cfg.chargeOverheatRecover),
    .delaySec(cfg.chargeOverheatDelay),
    .prohibit(otcProhibit),
    .switchOn(otcSwitch)
  );

  // discharge overheat qualifier
  ctzp_ot_qual #(.SEC_CYC(SEC_CYC)) uOtDsg (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .tempDc(tempDc),
    .tripDc(cfg.dischargeOverheatThreshold),
    .recoverDc(cfg.dischargeOverheatRecover),
    .delaySec(cfg.dischargeOverheatDelay),
    .prohibit(otdProhibit),
    .switchOn(otdSwitch)
  );

  // overheat outputs registered at the port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chargeProhibit <= 1'b0;
      dischargeProhibit <= 1'b0;
      chargeSwitch <= 1'b1;
      dischargeSwitch <= 1'b1;
    end else if (ce) begin
      chargeProhibit <= otcProhibit;
      dischargeProhibit <= otdProhibit;
      chargeSwitch <= otcSwitch;
      dischargeSwitch <= otdSwitch;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  relax_flag_a: assert property (
    ce |=> relaxing == (abs16($past(currentMa)) < $past(cfg.quitMa)))
    else $error("relax flag disagrees with current");
  sleep_block_a: assert property (
    ce && abs16(currentMa) >= cfg.sleepMa |=> !sleeping)
    else $error("sleep entered at high current");
  profile_use_a: assert property (
    ce && cfg.loadSel == 3'h0 |=> simCurrentMa == $past(stored.avgMa))
    else $error("simulation ignored stored current");
  profile_update_a: assert property (
    ce && cycleUpdate |=> stored.avgMw == $past(runAvg.avgMw))
    else $error("power profile not updated");
  cold_inhibit_a: assert property (
    ce && zoneNow == Z_COLD |=> !chargeAllow)
    else $error("charge allowed below boundary one");
  start_block_a: assert property (
    ce && !chargeRun && tempDc > cfg.zoneBoundaryFour |=> !chargeRun)
    else $error("charge started above boundary four");
  zone_hold_a: assert property (
    ce && zoneNow == Z_23 && tempDc <= cfg.zoneBoundaryThree
    && !below(tempDc, cfg.zoneBoundaryTwo, cfg.hys) |=> zoneNow == Z_23)
    else $error("zone left inside hysteresis band");
  zone_volt_a: assert property (
    ce && zoneNow == Z_34 |=> chgVoltMv == $past(cfg.v34))
    else $error("wrong charge voltage for zone");
  zone_pct_a: assert property (
    ce && zoneNow == Z_12 |=> chgCurPct == $past(cfg.i12))
    else $error("wrong charge current for zone");
  hot_suspend_a: assert property (
    ce && zoneNow == Z_HOT |=> !chargeAllow && chgVoltMv == 16'h0000)
    else $error("charging above boundary five");
endmodule // ctzp_top

// [sim/ctzp_host_model.sv]
// host and charger model: thermistor reading and charger plug events
`timescale 1ns/1ps
module ctzp_host_model (
  input wire logic clk_sys, // system clock
  input wire logic signed [15:0] goalDc, // temperature to present
  input wire logic chargerOn, // charger attached
  output logic signed [15:0] tempDc, // temperature seen by the gauge
  output logic chgStart, // charging event opens
  output logic chgStop // charging event closes
);
  logic lastOn = 1'h0; // charger state one cycle ago
  // reading lags one cycle, plug edges become one-cycle pulses
  always @(posedge clk_sys) begin
    tempDc <= goalDc;
    chgStart <= chargerOn & ~lastOn;
    chgStop <= ~chargerOn & lastOn;
    lastOn <= chargerOn;
  end
endmodule // ctzp_host_model

// [sim/ctzp_top_bench.sv]
// self-checking bench for the charge temperature zone protect block
`timescale 1ns/1ps
`include "ctzp_consts.svh"
module ctzp_top_bench;
  import ctzp_pkg::*;
  logic clk_sys = 1'h0, rst_n = 1'h0, ce = 1'h1; // clock, reset, enable
  logic cfgLoad = 1'h0, senseValid = 1'h0, dsgOnset = 1'h0; // strobes
  logic cycleUpdate = 1'h0, sleepReq = 1'h0, chargerOn = 1'h0; // requests
  ctzp_cfg_t cfgIn; // configuration set
  ctzp_prof_t runAvg = '0; // run averages
  logic signed [19:0] senseUv = 20'h00000; // sense voltage
  logic signed [15:0] goalDc = 16'h0000, livePowerMw = 16'h007B, tempDc; // temps, power
  logic signed [15:0] currentMa, simCurrentMa, simPowerMw; // converted values
  logic [15:0] chgVoltMv; // zone voltage
  logic [7:0] chgCurPct; // zone current
  ctzp_zone_t zoneNow; // active zone
  logic chgStart, chgStop, relaxing, sleeping, chargeAllow; // flags
  logic chargeProhibit, dischargeProhibit, chargeSwitch, dischargeSwitch; // overheat
  int error_cnt = 0, check_count = 0; // tallies
  wire logic [1:0] prB = {dischargeProhibit, chargeProhibit}; // prohibit by kind
  wire logic [1:0] swB = {dischargeSwitch, chargeSwitch}; // switch by kind
  // clock of 100 MHz
  always #5 clk_sys = ~clk_sys;
  ctzp_host_model u_host (.clk_sys(clk_sys), .goalDc(goalDc), .chargerOn(chargerOn),
    .tempDc(tempDc), .chgStart(chgStart), .chgStop(chgStop));
  ctzp_top #(.SEC_CYC(10)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cfgIn(cfgIn),
    .cfgLoad(cfgLoad), .senseUv(senseUv), .senseValid(senseValid), .tempDc(tempDc),
    .livePowerMw(livePowerMw), .dsgOnset(dsgOnset), .cycleUpdate(cycleUpdate),
    .runAvg(runAvg), .sleepReq(sleepReq), .chgStart(chgStart), .chgStop(chgStop),
    .currentMa(currentMa), .relaxing(relaxing), .sleeping(sleeping),
    .simCurrentMa(simCurrentMa), .simPowerMw(simPowerMw), .zoneNow(zoneNow),
    .chgVoltMv(chgVoltMv), .chgCurPct(chgCurPct), .chargeAllow(chargeAllow),
    .chargeProhibit(chargeProhibit), .dischargeProhibit(dischargeProhibit),
    .chargeSwitch(chargeSwitch), .dischargeSwitch(dischargeSwitch));
  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // compare a value
  task automatic chkv(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t value %h expected %h", $time, g, e);
    end
  endtask
  // compare a flag
  task automatic chkb(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, g, e);
    end
  endtask
  // counts, verdict, end of run
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one conversion, spaced past the divider latency
  task automatic conv(input logic signed [19:0] uv, input logic signed [15:0] ma);
    senseUv = uv;
    senseValid = 1'h1;
    tick(1);
    senseValid = 1'h0;
    tick(40);
    chkv(currentMa, ma);
  endtask
  // move temperature, settle, check zone outputs
  task automatic zstep(input logic signed [15:0] t, input ctzp_zone_t z,
                       input logic [15:0] v, input logic [7:0] p);
    goalDc = t;
    tick(9);
    chkv({10'h000, zoneNow}, {10'h000, z});
    chkv(chgVoltMv, v);
    chkv({8'h00, chgCurPct}, {8'h00, p});
  endtask
  // overheat walk: qualify, trip, recover, early cool-down
  task automatic ot(input int dis, input logic signed [15:0] thr, input logic signed [15:0] rec);
    goalDc = thr;
    tick(5);
    chkb(prB[dis], 1'h1);
    tick(40);
    chkb(swB[dis], 1'h1);
    tick(15);
    chkb(swB[dis], 1'h0);
    goalDc = rec + 16'h0001;
    tick(5);
    chkb(prB[dis], 1'h1);
    goalDc = rec;
    tick(5);
    chkb(prB[dis], 1'h0);
    chkb(swB[dis], 1'h1);
    goalDc = thr;
    tick(30);
    goalDc = thr - 16'h0001;
    tick(5);
    chkb(prB[dis], 1'h0);
    goalDc = thr;
    tick(40);
    chkb(swB[dis], 1'h1);
    goalDc = rec;
    tick(5);
  endtask
  // hang guard
  initial begin
    #100000;
    error_cnt++;
    close_out;
  end
  // main sequence
  initial begin
    cfgIn = {`CTZP_QUIT_MA, `CTZP_SLEEP_MA, `CTZP_BND1, `CTZP_BND2, `CTZP_BND3, `CTZP_BND4,
      `CTZP_BND5, `CTZP_HYS, `CTZP_V_LOW, `CTZP_V_LOW, `CTZP_V_MID, `CTZP_V_HIGH,
      `CTZP_PCT_COLD, `CTZP_PCT_WARM, `CTZP_PCT_WARM, `CTZP_PCT_WARM, `CTZP_OTC_THR,
      `CTZP_OTC_REC, `CTZP_OTD_THR, `CTZP_OTD_REC, `CTZP_OT_DELAY_S, `CTZP_OT_DELAY_S,
      `CTZP_GAIN_UOHM, `CTZP_LOAD_SEL};
    tick(3);
    chkv(simCurrentMa, 16'hFED5);
    chkv(simPowerMw, 16'hFB95);
    rst_n = 1'h1;
    conv(20'h000C8, 16'h0028);
    chkb(relaxing, 1'h0);
    conv(20'h000C3, 16'h0027);
    chkb(relaxing, 1'h1);
    sleepReq = 1'h1;
    conv(20'h0004B, 16'h000F);
    chkb(sleeping, 1'h0);
    conv(20'h00046, 16'h000E);
    chkb(sleeping, 1'h1);
    conv(20'hFFF38, 16'hFFD8);
    chkb(relaxing, 1'h0);
    dsgOnset = 1'h1;
    tick(2);
    chkv(simCurrentMa, 16'hFED5);
    chkv(simPowerMw, 16'hFB95);
    runAvg = {16'hFF9C, 16'hFE70};
    cycleUpdate = 1'h1;
    tick(1);
    cycleUpdate = 1'h0;
    dsgOnset = 1'h0;
    cfgIn.loadSel = 3'h0;
    cfgLoad = 1'h1;
    tick(1);
    cfgLoad = 1'h0;
    tick(3);
    chkv(simCurrentMa, 16'hFF9C);
    chkv(simPowerMw, 16'hFE70);
    zstep(16'h00FA, Z_23, 16'h10FE, 8'h50);
    zstep(16'h005F, Z_23, 16'h10FE, 8'h50);
    zstep(16'h0059, Z_12, 16'h10FE, 8'h32);
    zstep(16'h0064, Z_12, 16'h10FE, 8'h32);
    zstep(16'hFFFB, Z_12, 16'h10FE, 8'h32);
    zstep(16'hFFF5, Z_COLD, 16'h0000, 8'h00);
    zstep(16'h01CC, Z_34, 16'h10CC, 8'h50);
    zstep(16'h0226, Z_45, 16'h109A, 8'h50);
    zstep(16'h0262, Z_HOT, 16'h0000, 8'h00);
    zstep(16'h00C8, Z_23, 16'h10FE, 8'h50);
    // enable low: hot reading must neither move the zone nor start a qualifier
    ce = 1'h0;
    goalDc = 16'h0262;
    tick(9);
    chkv({10'h000, zoneNow}, {10'h000, Z_23});
    chkb(chargeProhibit, 1'h0);
    goalDc = 16'h00C8;
    tick(2);
    ce = 1'h1;
    chargerOn = 1'h1;
    tick(5);
    chkb(chargeAllow, 1'h1);
    chargerOn = 1'h0;
    goalDc = 16'h01FE;
    tick(9);
    chargerOn = 1'h1;
    tick(5);
    chkb(chargeAllow, 1'h0);
    ot(0, 16'h0226, 16'h01F4);
    ot(1, 16'h0258, 16'h0226);
    close_out;
  end
endmodule // ctzp_top_bench
